// [shared/nct_pkg.sv]
// Constants, field layouts and carrier types of the node identity, PHY access and cycle timer block
// Function
// - Clear node-valid bit 31 on bus reset; set it on new node number.
// - Set root bit 30 during bus reset processing when the PHY core is root.
// - Cable-power bit 27 follows the PHY core's cable power good report.
// - Bus index in bits 15:6 is writable by software.
// - Physical node index in bits 5:0 loads from the PHY core after self-ID.
// - Reserved node identity bits 29:28 and 26:16 read as zero.
// - Node identifier is bus index followed by node index, 16 bits.
// - Read-complete bit 31 clears when software sets read or write request.
// - Read-complete sets when a PHY register transfer returns, data updated together.
// - Bits 27:24 hold the address of the latest returned PHY register.
// - Bits 23:16 hold the contents returned for that address.
// - Bit 15 sends a PHY read request and clears once sent.
// - Bit 14 sends a PHY write request and clears once sent.
// - Target address from bits 11:8, write value from bits 7:0, ignored on reads.
// - As cycle master, the current timer value is each cycle start payload.
// - When not cycle master, received cycle starts load the timer.
// - Without cycle starts, the timer keeps advancing when run is enabled.
// - Seconds field in bits 31:25 counts period rollovers modulo 128.
// - Period field in bits 24:12 counts sub-period rollovers modulo 8000.
// - Sub-period field in bits 11:0 counts 24.576 MHz ticks modulo 3072.
// - Master enable and root node give a cycle start at every rollover.
// - Sub-period field advances only while timer run is enabled.
`default_nettype none
package nct_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int NCT_ADR_W = 9;
	localparam logic [NCT_ADR_W-1:0] OFS_LINK_CTRL = 9'h0f4;
	localparam logic [NCT_ADR_W-1:0] OFS_NODE_ID = 9'h0e8;
	localparam logic [NCT_ADR_W-1:0] OFS_PHY_ACCESS = 9'h0ec;
	localparam logic [NCT_ADR_W-1:0] OFS_CYCLE_TIME = 9'h0f0;
	// Node identity fields
	localparam int NID_VALID_BIT = 31;
	localparam int NID_ROOT_BIT = 30;
	localparam int NID_CPS_BIT = 27;
	localparam int NID_BUS_HI = 15;
	localparam int NID_BUS_LO = 6;
	localparam int NID_NODE_HI = 5;
	localparam logic [9:0] BUS_INDEX_RST = 10'h3ff;
	localparam logic [5:0] NODE_INDEX_RST = 6'h3f;
	// PHY access fields
	localparam int PHY_DONE_BIT = 31;
	localparam int PHY_RADDR_HI = 27;
	localparam int PHY_RADDR_LO = 24;
	localparam int PHY_RDATA_HI = 23;
	localparam int PHY_RDATA_LO = 16;
	localparam int PHY_RD_BIT = 15;
	localparam int PHY_WR_BIT = 14;
	localparam int PHY_TADDR_HI = 11;
	localparam int PHY_TADDR_LO = 8;
	localparam int PHY_WDATA_HI = 7;
	// Link control fields
	localparam int LC_MASTER_BIT = 21;
	localparam int LC_RUN_BIT = 20;
	// ----------------------------------------------------------------
	// Cycle timer
	// ----------------------------------------------------------------
	localparam logic [11:0] SUBPERIOD_MOD = 12'hc00;
	localparam logic [12:0] PERIOD_MOD = 13'h1f40;
	localparam logic [16:0] CLK_KHZ = 17'h0_9c40;
	localparam logic [16:0] TICK_KHZ = 17'h0_6000;
	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic write;
		logic [3:0] addr;
		logic [7:0] data;
	} nct_phy_req_s;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
	} nct_phy_ret_s;
	typedef struct packed {
		logic [6:0] seconds;
		logic [12:0] period;
		logic [11:0] subperiod;
	} nct_cycle_time_s;
	typedef enum logic [1:0] {PH_IDLE, PH_SEND, PH_WAIT} nct_phy_state_e;
endpackage
`default_nettype wire

// [rtl/nct_regs.sv]
// Node identity, PHY register access and isochronous cycle timer registers
`default_nettype none
module nct_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [nct_pkg::NCT_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic bus_reset_i,
	input wire logic self_id_done_i,
	input wire logic [5:0] phy_node_index_i,
	input wire logic phy_root_i,
	input wire logic cable_power_good_i,
	output logic phy_req_valid_o,
	output nct_pkg::nct_phy_req_s phy_req_o,
	input wire logic phy_req_ready_i,
	input wire logic phy_ret_valid_i,
	input wire nct_pkg::nct_phy_ret_s phy_ret_i,
	input wire logic cyc_start_rx_i,
	input wire nct_pkg::nct_cycle_time_s cyc_start_rx_data_i,
	output logic cyc_start_tx_o,
	output nct_pkg::nct_cycle_time_s cyc_start_payload_o,
	output logic [15:0] node_identifier_o,
	output logic node_id_valid_o
);
	import nct_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte-lane merge of a bus write into a register
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Cycle timer advanced by one tick with its three wraps
	function automatic nct_cycle_time_s ct_advance(input nct_cycle_time_s ct);
		nct_cycle_time_s res;
		res = ct;
		if (ct.subperiod == SUBPERIOD_MOD - 12'h001) begin
			res.subperiod = '0;
			if (ct.period == PERIOD_MOD - 13'h0001) begin
				res.period = '0;
				res.seconds = ct.seconds + 7'h01; // Wraps modulo 128
			end else begin
				res.period = ct.period + 13'h0001;
			end
		end else begin
			res.subperiod = ct.subperiod + 12'h001;
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [31:0] rd_mux;
	logic req_new;
	logic wr_node;
	logic wr_phy;
	logic wr_ct;
	logic wr_lc;
	logic [31:0] node_word;
	logic [31:0] phy_word;
	logic [31:0] lc_word;

	assign req_new = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wr_node = req_new && wb_we_i && (wb_adr_i == OFS_NODE_ID);
	assign wr_phy = req_new && wb_we_i && (wb_adr_i == OFS_PHY_ACCESS);
	assign wr_ct = req_new && wb_we_i && (wb_adr_i == OFS_CYCLE_TIME);
	assign wr_lc = req_new && wb_we_i && (wb_adr_i == OFS_LINK_CTRL);

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req_new;
		end
	end

	// Read data captured with the request; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (req_new && !wb_we_i) begin
			rdata_ff <= rd_mux;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;

	// ----------------------------------------------------------------
	// Node identity
	// ----------------------------------------------------------------
	logic node_valid_ff;
	logic root_ff;
	logic cps_ff;
	logic [9:0] bus_index_ff;
	logic [5:0] node_index_ff;
	logic [31:0] node_merged;

	assign node_merged = lane_merge(node_word, wb_dat_i, wb_sel_i);

	// Valid flag: new node number wins over a coincident bus reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			node_valid_ff <= 1'b0;
		end else if (self_id_done_i) begin
			node_valid_ff <= 1'b1;
		end else if (bus_reset_i) begin
			node_valid_ff <= 1'b0;
		end
	end

	// Root and node index captured at the end of self-identification
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			root_ff <= 1'b0;
			node_index_ff <= NODE_INDEX_RST;
		end else if (self_id_done_i) begin
			root_ff <= phy_root_i;
			node_index_ff <= phy_node_index_i;
		end
	end

	// Cable power status tracks the PHY core report
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cps_ff <= 1'b0;
		end else begin
			cps_ff <= cable_power_good_i;
		end
	end

	// Software-owned bus index
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_index_ff <= BUS_INDEX_RST;
		end else if (wr_node) begin
			bus_index_ff <= node_merged[NID_BUS_HI:NID_BUS_LO];
		end
	end

	// Read view; reserved bits stay zero
	always_comb begin
		node_word = 32'h0000_0000;
		node_word[NID_VALID_BIT] = node_valid_ff;
		node_word[NID_ROOT_BIT] = root_ff;
		node_word[NID_CPS_BIT] = cps_ff;
		node_word[NID_BUS_HI:NID_BUS_LO] = bus_index_ff;
		node_word[NID_NODE_HI:0] = node_index_ff;
	end

	// Node identifier and valid flag to the link logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			node_identifier_o <= {BUS_INDEX_RST, NODE_INDEX_RST};
			node_id_valid_o <= 1'b0;
		end else begin
			node_identifier_o <= {bus_index_ff, node_index_ff};
			node_id_valid_o <= node_valid_ff;
		end
	end

	// ----------------------------------------------------------------
	// PHY register access
	// ----------------------------------------------------------------
	logic rd_req_ff;
	logic wr_req_ff;
	logic done_ff;
	logic [3:0] ret_addr_ff;
	logic [7:0] ret_data_ff;
	logic [3:0] tgt_addr_ff;
	logic [7:0] wval_ff;
	logic sw_rd_set;
	logic sw_wr_set;
	logic sent;
	logic [31:0] phy_merged;
	nct_phy_state_e phy_st_ff;

	assign phy_merged = lane_merge(phy_word, wb_dat_i, wb_sel_i);
	assign sw_rd_set = wr_phy && wb_sel_i[1] && wb_dat_i[PHY_RD_BIT];
	assign sw_wr_set = wr_phy && wb_sel_i[1] && wb_dat_i[PHY_WR_BIT];
	assign sent = (phy_st_ff == PH_SEND) && phy_req_ready_i;

	// Request bits: set by software, cleared once sent; a new set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_req_ff <= 1'b0;
			wr_req_ff <= 1'b0;
		end else begin
			if (sw_rd_set) begin
				rd_req_ff <= 1'b1;
			end else if (sent && !phy_req_o.write) begin
				rd_req_ff <= 1'b0;
			end
			if (sw_wr_set) begin
				wr_req_ff <= 1'b1;
			end else if (sent && phy_req_o.write) begin
				wr_req_ff <= 1'b0;
			end
		end
	end

	// Target address and write value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tgt_addr_ff <= 4'h0;
			wval_ff <= 8'h00;
		end else if (wr_phy) begin
			tgt_addr_ff <= phy_merged[PHY_TADDR_HI:PHY_TADDR_LO];
			wval_ff <= phy_merged[PHY_WDATA_HI:0];
		end
	end

	// Completion flag: a returning transfer wins over a software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_ff <= 1'b0;
		end else if (phy_ret_valid_i) begin
			done_ff <= 1'b1;
		end else if (sw_rd_set || sw_wr_set) begin
			done_ff <= 1'b0;
		end
	end

	// Returned address and data, updated with the completion flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ret_addr_ff <= 4'h0;
			ret_data_ff <= 8'h00;
		end else if (phy_ret_valid_i) begin
			ret_addr_ff <= phy_ret_i.addr;
			ret_data_ff <= phy_ret_i.data;
		end
	end

	// One request in flight: a read waits for its returned transfer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phy_st_ff <= PH_IDLE;
			phy_req_valid_o <= 1'b0;
			phy_req_o <= '0;
		end else begin
			case (phy_st_ff)
				PH_IDLE: begin
					if (rd_req_ff || wr_req_ff) begin
						phy_req_valid_o <= 1'b1;
						phy_req_o.write <= !rd_req_ff;
						phy_req_o.addr <= tgt_addr_ff;
						phy_req_o.data <= rd_req_ff ? 8'h00 : wval_ff;
						phy_st_ff <= PH_SEND;
					end
				end
				PH_SEND: begin
					if (phy_req_ready_i) begin
						phy_req_valid_o <= 1'b0;
						phy_st_ff <= phy_req_o.write ? PH_IDLE : PH_WAIT;
					end
				end
				PH_WAIT: begin
					if (phy_ret_valid_i) begin
						phy_st_ff <= PH_IDLE;
					end
				end
				default: begin
					phy_st_ff <= PH_IDLE;
					phy_req_valid_o <= 1'b0;
				end
			endcase
		end
	end

	// Read view of the access register
	always_comb begin
		phy_word = 32'h0000_0000;
		phy_word[PHY_DONE_BIT] = done_ff;
		phy_word[PHY_RADDR_HI:PHY_RADDR_LO] = ret_addr_ff;
		phy_word[PHY_RDATA_HI:PHY_RDATA_LO] = ret_data_ff;
		phy_word[PHY_RD_BIT] = rd_req_ff;
		phy_word[PHY_WR_BIT] = wr_req_ff;
		phy_word[PHY_TADDR_HI:PHY_TADDR_LO] = tgt_addr_ff;
		phy_word[PHY_WDATA_HI:0] = wval_ff;
	end

	// ----------------------------------------------------------------
	// Link control and tick divider
	// ----------------------------------------------------------------
	logic master_en_ff;
	logic run_ff;
	logic [16:0] acc_ff;
	logic [16:0] acc_sum;
	logic tick;
	logic master_act;
	logic [31:0] lc_merged;

	assign lc_merged = lane_merge(lc_word, wb_dat_i, wb_sel_i);
	assign master_act = master_en_ff && root_ff;
	assign acc_sum = acc_ff + TICK_KHZ;
	assign tick = (acc_sum >= CLK_KHZ);

	// Master enable and timer run bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			master_en_ff <= 1'b0;
			run_ff <= 1'b0;
		end else if (wr_lc) begin
			master_en_ff <= lc_merged[LC_MASTER_BIT];
			run_ff <= lc_merged[LC_RUN_BIT];
		end
	end

	// Fractional divider: 24.576 MHz tick enables from the system clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_ff <= 17'h0_0000;
		end else begin
			acc_ff <= tick ? acc_sum - CLK_KHZ : acc_sum;
		end
	end

	always_comb begin
		lc_word = 32'h0000_0000;
		lc_word[LC_MASTER_BIT] = master_en_ff;
		lc_word[LC_RUN_BIT] = run_ff;
	end

	// ----------------------------------------------------------------
	// Cycle timer
	// ----------------------------------------------------------------
	nct_cycle_time_s ct_ff;
	nct_cycle_time_s ct_next;
	logic roll;

	assign ct_next = ct_advance(ct_ff);
	assign roll = run_ff && tick && (ct_ff.subperiod == SUBPERIOD_MOD - 12'h001);

	// Software write, then received cycle start, then local counting
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ct_ff <= '0;
		end else if (wr_ct) begin
			ct_ff <= lane_merge(ct_ff, wb_dat_i, wb_sel_i);
		end else if (!master_act && cyc_start_rx_i) begin
			ct_ff <= cyc_start_rx_data_i;
		end else if (run_ff && tick) begin
			ct_ff <= ct_next;
		end
	end

	// Cycle start out at each rollover while master and root
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cyc_start_tx_o <= 1'b0;
			cyc_start_payload_o <= '0;
		end else begin
			cyc_start_tx_o <= master_act && roll && !wr_ct;
			if (master_act && roll && !wr_ct) begin
				cyc_start_payload_o <= ct_next;
			end
		end
	end

	// Register read selection
	always_comb begin
		case (wb_adr_i)
			OFS_NODE_ID: rd_mux = node_word;
			OFS_PHY_ACCESS: rd_mux = phy_word;
			OFS_CYCLE_TIME: rd_mux = ct_ff;
			OFS_LINK_CTRL: rd_mux = lc_word;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	valid_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_reset_i && !self_id_done_i |=> !node_valid_ff ##1 !node_id_valid_o)
		else $error("node valid not cleared by bus reset");
	node_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		self_id_done_i |=> node_index_ff == $past(phy_node_index_i) && root_ff == $past(phy_root_i))
		else $error("node index or root not loaded");
	node_ident_a: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 node_identifier_o == {$past(bus_index_ff), $past(node_index_ff)})
		else $error("node identifier mismatch");
	reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && !wb_we_i && wb_adr_i == OFS_NODE_ID |=> wb_ack_o && wb_dat_o[29:28] == 2'b00
		&& wb_dat_o[26:16] == 11'h000 && wb_dat_o[NID_CPS_BIT] == $past(cps_ff))
		else $error("node identity read wrong");
	done_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(sw_rd_set || sw_wr_set) && !phy_ret_valid_i |=> !done_ff)
		else $error("read complete not cleared");
	done_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		phy_ret_valid_i |=> done_ff && ret_addr_ff == $past(phy_ret_i.addr)
		&& ret_data_ff == $past(phy_ret_i.data))
		else $error("returned transfer not recorded");
	req_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sent && !phy_req_o.write && !sw_rd_set |=> !rd_req_ff ##1 phy_st_ff != PH_SEND)
		else $error("read request not cleared after send");
	req_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		phy_req_valid_o && !phy_req_ready_i |=> phy_req_valid_o && $stable(phy_req_o))
		else $error("request dropped before accepted");
	offset_frozen_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!run_ff && !wr_ct && !cyc_start_rx_i |=> $stable(ct_ff))
		else $error("timer moved while stopped");
	offset_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		roll && !wr_ct && !(cyc_start_rx_i && !master_act) |=> ct_ff.subperiod == 12'h000)
		else $error("sub-period did not wrap at 3072");
	period_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		roll && ct_ff.period == PERIOD_MOD - 13'h0001 && !wr_ct && !(cyc_start_rx_i && !master_act)
		|=> ct_ff.period == 13'h0000 && ct_ff.seconds == $past(ct_ff.seconds) + 7'h01)
		else $error("period did not wrap at 8000");
	rx_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cyc_start_rx_i && !master_act && !wr_ct |=> ct_ff == $past(cyc_start_rx_data_i))
		else $error("received cycle start not loaded");
	master_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cyc_start_tx_o |-> cyc_start_payload_o == ct_ff && ct_ff.subperiod == 12'h000)
		else $error("cycle start payload differs from timer");

endmodule // nct_regs
`default_nettype wire

// [tb/nct_phy_model.sv]
// Behavioural PHY core that answers register requests from the link
`default_nettype none
module nct_phy_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire nct_pkg::nct_phy_req_s req_i,
	output logic req_ready_o,
	output logic ret_valid_o,
	output nct_pkg::nct_phy_ret_s ret_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import nct_pkg::*;
	logic [7:0] mem [16];
	logic slow;
	logic [3:0] rd_a;
	int wait_n;
	int ret_n;
	// ----------------------------------------------------------------
	// Request acceptance and read return
	// ----------------------------------------------------------------
	// One request at a time, alternately prompt and slow
	always @(posedge clk_i) begin
		if (rst_i) begin
			req_ready_o <= 1'h0;
			ret_valid_o <= 1'h0;
			ret_o <= '0;
			slow <= 1'h0;
			wait_n <= 0;
			ret_n <= 0;
			// Register file starts from a known pattern
			for (int i = 0; i < 16; i++) mem[i] <= {i[3:0], ~i[3:0]};
		end else begin
			ret_valid_o <= 1'h0;
			ret_o <= ~ret_o; // Idle return lines do not hold old data
			if (req_valid_i && req_ready_o) begin
				req_ready_o <= 1'h0;
				slow <= ~slow;
				if (req_i.write) begin
					mem[req_i.addr] <= req_i.data;
				end else begin
					rd_a <= req_i.addr;
					ret_n <= slow ? 6 : 1;
				end
			end else if (req_valid_i) begin
				wait_n <= wait_n + 1;
				if (wait_n >= (slow ? 4 : 0)) begin
					req_ready_o <= 1'h1;
					wait_n <= 0;
				end
			end
			if (ret_n > 0) begin
				ret_n <= ret_n - 1;
			end
			if (ret_n == 1) begin
				ret_valid_o <= 1'h1;
				ret_o <= {rd_a, mem[rd_a]};
			end
		end
	end
endmodule // nct_phy_model
`default_nettype wire

// [tb/node_id_phy_access_cycle_timer_tb.sv]
// Self-checking bench for the node identity, PHY access and cycle timer registers
`default_nettype none
module node_id_phy_access_cycle_timer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import nct_pkg::*;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, wb_ack;
	logic [NCT_ADR_W-1:0] wb_adr = '0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdat = '0, wb_rdat;
	logic bus_reset = 1'h0, sid_done = 1'h0, root = 1'h0, cpg = 1'h0;
	logic [5:0] node_idx = '0;
	logic req_valid, req_ready, ret_valid, rx_stb = 1'h0, tx_stb, nid_valid;
	nct_phy_req_s req;
	nct_phy_ret_s ret;
	nct_cycle_time_s rx_data = '0, payload;
	logic [15:0] node_ident;
	int failures = 0, samples_checked = 0;
	logic [31:0] seed = 32'h8ce9_8056;
	logic [7:0] shadow [16];
	logic [3:0] ret_a = 4'h0;
	logic [7:0] ret_d = 8'h00;
	initial forever #12.5 clk_i = ~clk_i;
	nct_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .bus_reset_i(bus_reset),
		.self_id_done_i(sid_done), .phy_node_index_i(node_idx), .phy_root_i(root),
		.cable_power_good_i(cpg), .phy_req_valid_o(req_valid), .phy_req_o(req),
		.phy_req_ready_i(req_ready), .phy_ret_valid_i(ret_valid), .phy_ret_i(ret),
		.cyc_start_rx_i(rx_stb), .cyc_start_rx_data_i(rx_data), .cyc_start_tx_o(tx_stb),
		.cyc_start_payload_o(payload), .node_identifier_o(node_ident),
		.node_id_valid_o(nid_valid));
	nct_phy_model phy (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid), .req_i(req),
		.req_ready_o(req_ready), .ret_valid_o(ret_valid), .ret_o(ret));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] nid(input logic v, r, c, input logic [9:0] b,
		input logic [5:0] n);
		return {v, r, 2'h0, c, 11'h000, b, n};
	endfunction
	function automatic logic [31:0] legal_time();
		return {7'(rnd()), 13'(rnd() % 8000), 12'(rnd() % 3072)};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic single Wishbone cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [NCT_ADR_W-1:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= wd;
		wb_sel <= 4'hf;
		do @(posedge clk_i); while (wb_ack !== 1'h1);
		rd = wb_rdat;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
		@(posedge clk_i);
	endtask
	// PHY register request, then poll until it completes
	task automatic phy_op(input logic we, input logic [3:0] a, input logic [7:0] v);
		logic [31:0] rd;
		int n;
		wb(1'h1, OFS_PHY_ACCESS, {16'h0000, ~we, we, 2'h0, a, v}, rd);
		wb(1'h0, OFS_PHY_ACCESS, 32'h0000_0000, rd);
		chk(32'(rd[31]), 32'h0000_0000);
		n = 0;
		while ((we ? rd[14] : !rd[31]) && n < 40) begin
			wb(1'h0, OFS_PHY_ACCESS, 32'h0000_0000, rd);
			n++;
		end
		if (we) shadow[a] = v;
		else begin
			ret_a = a;
			ret_d = shadow[a];
		end
		chk(rd, {~we, 3'h0, ret_a, ret_d, 4'h0, a, v});
	endtask
	task automatic print_verdict();
		if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		print_verdict();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rd, wd, tv;
		logic [5:0] nd;
		logic cp;
		int n;
		for (int i = 0; i < 16; i++) shadow[i] = {i[3:0], ~i[3:0]};
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		wb(1'h0, OFS_NODE_ID, 32'h0000_0000, rd);
		chk(rd, 32'h0000_ffff);
		// Node index 63 after reset: software must hold off transmit until self-ID
		chk(32'(node_ident), 32'h0000_ffff);
		wb(1'h0, 9'h1fc, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		// Self-identification delivers a node number
		nd = 6'(rnd());
		cp = 1'(rnd());
		node_idx <= nd;
		root <= 1'h1;
		cpg <= cp;
		sid_done <= 1'h1;
		@(posedge clk_i);
		sid_done <= 1'h0;
		@(posedge clk_i);
		wb(1'h0, OFS_NODE_ID, 32'h0000_0000, rd);
		chk(rd, nid(1'h1, 1'h1, cp, 10'h3ff, nd));
		wd = rnd();
		wb(1'h1, OFS_NODE_ID, wd, rd);
		wb(1'h0, OFS_NODE_ID, 32'h0000_0000, rd);
		chk(rd, nid(1'h1, 1'h1, cp, wd[15:6], nd));
		chk(32'({nid_valid, node_ident}), 32'({1'h1, wd[15:6], nd}));
		bus_reset <= 1'h1;
		@(posedge clk_i);
		bus_reset <= 1'h0;
		@(posedge clk_i);
		wb(1'h0, OFS_NODE_ID, 32'h0000_0000, rd);
		chk(rd, nid(1'h0, 1'h1, cp, wd[15:6], nd));
		// Back-to-back PHY reads and writes, never both bits at once
		for (int i = 0; i < 10; i++) begin
			wd = rnd();
			// First three: read, write, read back one fixed address
			phy_op(i < 3 ? i[0] : wd[31], i < 3 ? 4'h5 : wd[11:8], wd[7:0]);
		end
		// Rollover of every timer field as cycle master and root
		wb(1'h1, OFS_CYCLE_TIME, {7'h7f, 13'h1f3f, 12'hbf4}, rd);
		wb(1'h1, OFS_LINK_CTRL, 32'h0030_0000, rd);
		for (n = 0; n < 200 && tx_stb !== 1'h1; n++) @(posedge clk_i);
		chk(32'(tx_stb), 32'h0000_0001);
		chk(payload, 32'h0000_0000);
		// Next rollover 3072 ticks later, 5000 clocks at 24.576 MHz from 40 MHz
		@(posedge clk_i);
		for (n = 0; n < 5200 && tx_stb !== 1'h1; n++) @(posedge clk_i);
		chk(32'(n), 32'h0000_1387);
		chk(payload, 32'h0000_1000);
		// Timer stays frozen with run clear
		wb(1'h1, OFS_LINK_CTRL, 32'h0000_0000, rd);
		tv = legal_time();
		wb(1'h1, OFS_CYCLE_TIME, tv, rd);
		repeat (10) @(posedge clk_i);
		wb(1'h0, OFS_CYCLE_TIME, 32'h0000_0000, rd);
		chk(rd, tv);
		// Received cycle start loads the timer when not master
		tv = legal_time();
		rx_data <= tv;
		rx_stb <= 1'h1;
		@(posedge clk_i);
		rx_stb <= 1'h0;
		@(posedge clk_i);
		wb(1'h0, OFS_CYCLE_TIME, 32'h0000_0000, rd);
		chk(rd, tv);
		print_verdict();
	end
endmodule // node_id_phy_access_cycle_timer_tb
`default_nettype wire
